// ==== rtl/nand_feature_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - 0FH reads, 1FH writes, selector byte follows
// - status read-only; write latch set by 06H
// - settings hold until rewritten, survive soft reset
// - A0/B0/D0 read-write, C0/F0 read-only
// - guard high and protect pin low blocks A0
// - one-time lock non-volatile, rest volatile
// - four-line transfers only while quad allowed
// - guard powers up 0, soft reset keeps
// - levels power up 1, selectors 0
// - correction enable powers up as 1
// - correction applied per enable bit
// - freeze blocks protection bits until power cycle
// - freeze reads 0 after power-on
// - correction fields cleared on soft reset, read start
// - correction fields loaded after valid read
// - correction fields meaningless when correction off
// - power-on fields show block 0 page 0
// - write latch set/cleared; gates program, erase
// - running flag while array or reset busy
// - program fault set on fail, cleared
// - result codes: 00 clean, 01 fixed, 10 lost
module nand_feature_regs (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       mosi_i,
  input  wire logic                       wp_n_i,
  output logic                            miso_o,
  output logic                            miso_oe_n_o,
  input  wire logic                       otp_lock_nv_i,
  input  wire nand_feature_pkg::ecc_s     page0_ecc_i,
  input  wire logic                       array_busy_i,
  input  wire logic                       read_start_i,
  input  wire logic                       read_done_i,
  input  wire nand_feature_pkg::ecc_s     read_ecc_i,
  input  wire logic                       program_exec_i,
  input  wire logic                       program_fail_i,
  input  wire logic                       erase_start_i,
  input  wire logic                       erase_fail_i,
  input  wire logic                       block_protected_i,
  output nand_feature_pkg::protect_s      protect_o,
  output nand_feature_pkg::feature_s      feature_o,
  output logic [1:0]                      drive_sel_o,
  output logic                            write_permit_o,
  output logic                            soft_reset_o
);
  import nand_feature_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_q_reg;
  logic [1:0] cs_q_reg;
  logic [1:0] mosi_q_reg;
  logic [1:0] wp_q_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_q_reg <= 3'h0;
      cs_q_reg   <= 2'h3;
      mosi_q_reg <= 2'h0;
      wp_q_reg   <= 2'h3;
    end else if (ce_i) begin
      sclk_q_reg <= {sclk_q_reg[1:0], sclk_i};
      cs_q_reg   <= {cs_q_reg[0], cs_n_i};
      mosi_q_reg <= {mosi_q_reg[0], mosi_i};
      wp_q_reg   <= {wp_q_reg[0], wp_n_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic mosi_bit;
  logic wp_low;

  assign sclk_rise = sclk_q_reg[1] & ~sclk_q_reg[2];
  assign sclk_fall = ~sclk_q_reg[1] & sclk_q_reg[2];
  assign cs_active = ~cs_q_reg[1];
  assign mosi_bit  = mosi_q_reg[1];
  assign wp_low    = ~wp_q_reg[1];

  // ----------------------------------------------------------------
  // link byte framing
  // ----------------------------------------------------------------
  link_state_e state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  op_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  rx_byte;
  logic        byte_done;

  assign rx_byte   = {shift_reg[6:0], mosi_bit};
  assign byte_done = cs_active & ce_i & sclk_rise & (bit_cnt_reg == BIT_LAST);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_CMD;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      op_reg      <= 8'h00;
      addr_reg    <= 8'h00;
    end else if (ce_i) begin
      if (!cs_active) begin
        state_reg   <= ST_CMD;
        bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
        shift_reg   <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == BIT_LAST) begin
          case (state_reg)
            ST_CMD: begin
              op_reg    <= rx_byte;
              state_reg <= (rx_byte == OP_GET || rx_byte == OP_SET) ? ST_ADDR : ST_SKIP;
            end
            ST_ADDR: begin
              addr_reg  <= rx_byte;
              state_reg <= ST_DATA;
            end
            // one data byte per write; reads keep repeating
            ST_DATA: state_reg <= (op_reg == OP_SET) ? ST_SKIP : ST_DATA;
            default: state_reg <= state_reg;
          endcase
        end
      end
    end
  end

  logic       cmd_byte;
  logic       wr_commit;
  logic       rd_reload;
  logic       soft_rst;
  logic [7:0] rd_sel;

  assign cmd_byte  = byte_done & (state_reg == ST_CMD);
  assign wr_commit = byte_done & (state_reg == ST_DATA) & (op_reg == OP_SET);
  assign rd_reload = byte_done & (op_reg == OP_GET)
                     & (state_reg == ST_ADDR || state_reg == ST_DATA);
  assign soft_rst  = cmd_byte & (rx_byte == OP_SOFT_RESET);
  assign rd_sel    = (state_reg == ST_ADDR) ? rx_byte : addr_reg;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  protect_s   protect_reg;
  feature_s   feature_reg;
  ecc_s       ecc_reg;
  logic [1:0] drive_reg;
  logic       boot_reg;
  logic       wel_reg;
  logic       p_fail_reg;
  logic       e_fail_reg;
  logic       busy_reg;
  logic       bps_reg;
  logic       soft_reset_reg;
  logic       protect_wr_ok;

  // guard with protect pin low refuses the write
  assign protect_wr_ok = !(protect_reg.guard && wp_low) && !feature_reg.freeze;

  // first enabled cycle after release restores non-volatile state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_reg <= 1'h1;
    end else if (ce_i) begin
      boot_reg <= 1'h0;
    end
  end

  // power-on defaults, untouched by soft reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      protect_reg <= PROTECT_RST;
    end else if (ce_i && wr_commit && addr_reg == ADDR_PROTECT && protect_wr_ok) begin
      protect_reg.guard      <= rx_byte[POS_GUARD];
      protect_reg.level      <= rx_byte[POS_LEVEL_HI:POS_LEVEL_LO];
      protect_reg.invert     <= rx_byte[POS_INVERT];
      protect_reg.complement <= rx_byte[POS_COMPLEMENT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      feature_reg <= FEATURE_RST;
    end else if (ce_i) begin
      if (boot_reg) begin
        // lock bit restored from non-volatile store
        feature_reg.otp_lock <= otp_lock_nv_i;
      end else if (wr_commit && addr_reg == ADDR_FEATURE) begin
        // lock and freeze only ever set; clearing needs power cycle
        feature_reg.otp_lock   <= feature_reg.otp_lock | rx_byte[POS_OTP_LOCK];
        feature_reg.otp_access <= rx_byte[POS_OTP_ACCESS];
        feature_reg.ecc_on     <= rx_byte[POS_ECC_ON];
        feature_reg.freeze     <= feature_reg.freeze | rx_byte[POS_FREEZE];
        feature_reg.quad       <= rx_byte[POS_QUAD];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drive_reg <= DRIVE_RST;
    end else if (ce_i && wr_commit && addr_reg == ADDR_DRIVE) begin
      drive_reg <= rx_byte[POS_DRIVE_HI:POS_DRIVE_LO];
    end
  end

  // latch set only by command, set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wel_reg <= 1'h0;
    end else if (ce_i) begin
      if (cmd_byte && rx_byte == OP_WREN) begin
        wel_reg <= 1'h1;
      end else if ((cmd_byte && rx_byte == OP_WRDI) || soft_rst) begin
        wel_reg <= 1'h0;
      end
    end
  end

  // fault flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      p_fail_reg <= 1'h0;
      e_fail_reg <= 1'h0;
    end else if (ce_i) begin
      if (program_fail_i) begin
        p_fail_reg <= 1'h1;
      end else if (program_exec_i || soft_rst) begin
        p_fail_reg <= 1'h0;
      end
      if (erase_fail_i) begin
        e_fail_reg <= 1'h1;
      end else if (erase_start_i || soft_rst) begin
        e_fail_reg <= 1'h0;
      end
    end
  end

  // fields still tracked with correction off
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ecc_reg <= ECC_CLEAR;
    end else if (ce_i) begin
      if (boot_reg) begin
        ecc_reg <= page0_ecc_i;
      end else if (read_done_i) begin
        ecc_reg <= read_ecc_i;
      end else if (read_start_i || soft_rst) begin
        ecc_reg <= ECC_CLEAR;
      end
    end
  end

  // busy includes the soft reset cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_reg       <= 1'h0;
      bps_reg        <= 1'h0;
      soft_reset_reg <= 1'h0;
    end else if (ce_i) begin
      busy_reg       <= array_busy_i | soft_rst;
      bps_reg        <= block_protected_i;
      soft_reset_reg <= soft_rst;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] read_data;

  always_comb begin
    case (rd_sel)
      ADDR_PROTECT:  read_data = {protect_reg.guard, 1'b0, protect_reg.level,
                                  protect_reg.invert, protect_reg.complement, 1'b0};
      ADDR_FEATURE:  read_data = {feature_reg.otp_lock, feature_reg.otp_access, 1'b0,
                                  feature_reg.ecc_on, feature_reg.freeze, 2'b00,
                                  feature_reg.quad};
      ADDR_STATUS:   read_data = {2'b00, ecc_reg.result, p_fail_reg, e_fail_reg,
                                  wel_reg, busy_reg};
      ADDR_DRIVE:    read_data = {1'b0, drive_reg, 5'b00000};
      ADDR_EXT_STAT: read_data = {2'b00, ecc_reg.count, bps_reg, 3'b000};
      default:       read_data = 8'h00;
    endcase
  end

  logic [7:0] tx_reg;
  logic       miso_reg;
  logic       oe_n_reg;

  // reload each byte so status polling sees fresh busy state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_reg   <= 8'h00;
      miso_reg <= 1'h0;
      oe_n_reg <= 1'h1;
    end else if (ce_i) begin
      if (rd_reload) begin
        tx_reg <= read_data;
      end else if (cs_active && sclk_fall) begin
        tx_reg   <= {tx_reg[6:0], tx_reg[7]};
        miso_reg <= tx_reg[7];
      end
      oe_n_reg <= ~(cs_active && state_reg == ST_DATA && op_reg == OP_GET);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // quad and correction enables steer the engines
  assign protect_o      = protect_reg;
  assign feature_o      = feature_reg;
  assign drive_sel_o    = drive_reg;
  assign write_permit_o = wel_reg;
  assign soft_reset_o   = soft_reset_reg;
  assign miso_o         = miso_reg;
  assign miso_oe_n_o    = oe_n_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  guard_block_a: assert property (
    ce_i && wr_commit && addr_reg == ADDR_PROTECT && protect_reg.guard && wp_low
    |=> $stable(protect_reg))
    else $error("protection changed while guarded");

  freeze_hold_a: assert property (
    feature_reg.freeze |=> feature_reg.freeze && $stable(protect_reg))
    else $error("frozen protection changed");

  wel_set_a: assert property (
    cmd_byte && rx_byte == OP_WREN |=> wel_reg ##0 read_data[1] || rd_sel != ADDR_STATUS)
    else $error("write latch not set");

  status_ro_a: assert property (
    wr_commit && (addr_reg == ADDR_STATUS || addr_reg == ADDR_EXT_STAT)
    |=> $stable(protect_reg) && $stable(drive_reg) && $stable(feature_reg))
    else $error("read-only write stored");

  soft_keep_a: assert property (
    soft_rst |=> $stable(feature_reg) && $stable(protect_reg) && !wel_reg
    ##1 soft_reset_o == 1'b0)
    else $error("soft reset disturbed settings");

  ecc_clear_a: assert property (
    ce_i && !boot_reg && read_start_i && !read_done_i |=> ecc_reg == ECC_CLEAR)
    else $error("correction fields not cleared");

  ecc_load_a: assert property (
    ce_i && !boot_reg && read_done_i |=> ecc_reg == $past(read_ecc_i))
    else $error("correction fields not loaded");

  pfail_set_a: assert property (
    ce_i && program_fail_i |=> p_fail_reg [*1] ##1 (p_fail_reg || $past(program_exec_i)
    || $past(soft_rst)))
    else $error("program fault lost");

  reset_value_a: assert property (
    $rose(rst_n_i) |-> protect_reg == PROTECT_RST && !feature_reg.freeze && feature_reg.ecc_on)
    else $error("wrong power-on value");

  read_cover_c: cover property (rd_reload && rd_sel == ADDR_STATUS);
  write_cover_c: cover property (wr_commit && addr_reg == ADDR_FEATURE);
  soft_cover_c: cover property (soft_rst);

endmodule

`default_nettype wire

// ==== shared/nand_feature_pkg.sv ====
`default_nettype none

package nand_feature_pkg;

  // ----------------------------------------------------------------
  // link opcodes and register selectors
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_GET        = 8'h0F;
  localparam logic [7:0] OP_SET        = 8'h1F;
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  localparam logic [7:0] OP_SOFT_RESET = 8'hFF;
  localparam logic [7:0] ADDR_PROTECT  = 8'hA0;
  localparam logic [7:0] ADDR_FEATURE  = 8'hB0;
  localparam logic [7:0] ADDR_STATUS   = 8'hC0;
  localparam logic [7:0] ADDR_DRIVE    = 8'hD0;
  localparam logic [7:0] ADDR_EXT_STAT = 8'hF0;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_GUARD      = 7;
  localparam int POS_LEVEL_HI   = 5;
  localparam int POS_LEVEL_LO   = 3;
  localparam int POS_INVERT     = 2;
  localparam int POS_COMPLEMENT = 1;
  localparam int POS_OTP_LOCK   = 7;
  localparam int POS_OTP_ACCESS = 6;
  localparam int POS_ECC_ON     = 4;
  localparam int POS_FREEZE     = 3;
  localparam int POS_QUAD       = 0;
  localparam int POS_DRIVE_HI   = 6;
  localparam int POS_DRIVE_LO   = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CMD  = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_SKIP = 2'b11
  } link_state_e;

  typedef struct packed {
    logic       guard;
    logic [2:0] level;
    logic       invert;
    logic       complement;
  } protect_s;

  typedef struct packed {
    logic otp_lock;
    logic otp_access;
    logic ecc_on;
    logic freeze;
    logic quad;
  } feature_s;

  typedef struct packed {
    logic [1:0] result;
    logic [1:0] count;
  } ecc_s;

  // ----------------------------------------------------------------
  // values after power-on reset
  // ----------------------------------------------------------------
  localparam protect_s PROTECT_RST = '{guard: 1'h0, level: 3'h7, invert: 1'h0,
                                       complement: 1'h0};
  localparam feature_s FEATURE_RST = '{otp_lock: 1'h0, otp_access: 1'h0, ecc_on: 1'h1,
                                       freeze: 1'h0, quad: 1'h0};
  localparam ecc_s     ECC_CLEAR   = '{result: 2'h0, count: 2'h0};
  localparam logic [1:0] DRIVE_RST = 2'h0;

endpackage

`default_nettype wire

// ==== dv/spi_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);

  // mode 0: clock rests low and stands still between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // link tasks
  // ----------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // half periods of 6 and 7 clocks, 65 ns a bit
  // reserved bits go out exactly as the caller gives them
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      wait_clk(6);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      wait_clk(7);
      sclk_o = 1'b0;
    end
  endtask

  // opcode, then selector if n > 1, then one data byte if n > 2
  task automatic xfer(input logic [7:0] op,
                      input logic [7:0] sel,
                      input logic [7:0] wd,
                      input int         n,
                      output logic [7:0] rd);
    logic [7:0] junk;
    rd = 8'h00;
    cs_n_o = 1'b0;
    wait_clk(6);
    shift_byte(op, junk);
    if (n > 1) shift_byte(sel, junk);
    if (n > 2) shift_byte(wd, rd);
    wait_clk(6);
    cs_n_o = 1'b1;
    // idle data line must not keep a stale value
    mosi_o = ~mosi_o;
    wait_clk(8);
  endtask

endmodule

`default_nettype wire

// ==== dv/serial_nand_feature_registers_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_nand_feature_registers_tb_top;
  import nand_feature_pkg::*;

  logic       clk;
  logic       ce;
  logic       rst_n;
  logic       wp_n;
  logic       otp_nv;
  ecc_s       page0_ecc;
  ecc_s       read_ecc;
  logic       array_busy;
  logic       block_prot;
  logic [5:0] strobes;
  protect_s   protect;
  feature_s   feature;
  logic [1:0] drive_sel;
  logic       write_permit;
  logic       soft_reset;
  logic       miso;
  logic       miso_oe_n;
  logic       miso_last;
  wire        miso_line;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  int         mismatches;
  int         n_tests;
  int         n_soft;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  nand_feature_regs u_nand_feature_regs (
    .clk_i            (clk),
    .rst_n_i          (rst_n),
    .ce_i             (ce),
    .sclk_i           (sclk),
    .cs_n_i           (cs_n),
    .mosi_i           (mosi),
    .wp_n_i           (wp_n),
    .miso_o           (miso),
    .miso_oe_n_o      (miso_oe_n),
    .otp_lock_nv_i    (otp_nv),
    .page0_ecc_i      (page0_ecc),
    .array_busy_i     (array_busy),
    .read_start_i     (strobes[0]),
    .read_done_i      (strobes[1]),
    .read_ecc_i       (read_ecc),
    .program_exec_i   (strobes[3]),
    .program_fail_i   (strobes[2]),
    .erase_start_i    (strobes[5]),
    .erase_fail_i     (strobes[4]),
    .block_protected_i(block_prot),
    .protect_o        (protect),
    .feature_o        (feature),
    .drive_sel_o      (drive_sel),
    .write_permit_o   (write_permit),
    .soft_reset_o     (soft_reset)
  );

  spi_host_model u_spi_host_model (
    .clk_i (clk),
    .miso_i(miso_line),
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .mosi_o(mosi)
  );

  // released data line shows the inverse of its last driven level
  assign miso_line = miso_oe_n ? ~miso_last : miso;

  always @(posedge clk) begin
    if (miso_oe_n === 1'b0) miso_last <= miso;
    if (soft_reset === 1'b1) n_soft++;
  end

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] sel, input logic [7:0] exp);
    logic [7:0] v;
    u_spi_host_model.xfer(OP_GET, sel, 8'h00, 3, v);
    check(v, exp);
  endtask

  task automatic wr(input logic [7:0] sel, input logic [7:0] d);
    logic [7:0] v;
    u_spi_host_model.xfer(OP_SET, sel, d, 3, v);
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] v;
    u_spi_host_model.xfer(op, 8'h00, 8'h00, 1, v);
  endtask

  // one-cycle pulse on one array strobe
  task automatic strobe(input int k);
    strobes = 6'h01 << k;
    step(1);
    strobes = 6'h00;
    step(2);
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset(input logic nv, input logic [7:0] exp_feat);
    rst_n = 1'b0;
    otp_nv = nv;
    step(5);
    rst_n = 1'b1;
    step(3);
    check({2'b00, protect}, 8'h1c);
    rd(ADDR_PROTECT, 8'h38);
    rd(ADDR_FEATURE, exp_feat);
    rd(ADDR_STATUS, 8'h10);
    rd(ADDR_EXT_STAT, 8'h20);
    rd(ADDR_DRIVE, 8'h00);
    rd(8'h55, 8'h00);
  endtask

  task automatic t_rw;
    wr(ADDR_FEATURE, 8'h01);
    rd(ADDR_FEATURE, 8'h81);
    check({3'b000, feature}, 8'h11);
    wr(ADDR_FEATURE, 8'h11);
    check({3'b000, feature}, 8'h15);
    wr(ADDR_DRIVE, 8'h60);
    rd(ADDR_DRIVE, 8'h60);
    check({6'h00, drive_sel}, 8'h03);
    wr(ADDR_PROTECT, 8'h2c);
    rd(ADDR_PROTECT, 8'h2c);
    check({2'b00, protect}, 8'h16);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h10);
    wr(ADDR_EXT_STAT, 8'hff);
    rd(ADDR_EXT_STAT, 8'h20);
    wr(8'h55, 8'hff);
    rd(ADDR_PROTECT, 8'h2c);
    rd(ADDR_FEATURE, 8'h91);
  endtask

  task automatic t_guard;
    wr(ADDR_PROTECT, 8'h80);
    wp_n = 1'b0;
    step(4);
    wr(ADDR_PROTECT, 8'h38);
    rd(ADDR_PROTECT, 8'h80);
    wp_n = 1'b1;
    step(4);
    // keep the guard set so later scenarios see it survive
    wr(ADDR_PROTECT, 8'hb8);
    rd(ADDR_PROTECT, 8'hb8);
  endtask

  task automatic t_wel;
    cmd(OP_WREN);
    rd(ADDR_STATUS, 8'h12);
    check({7'h00, write_permit}, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h12);
    cmd(OP_WRDI);
    rd(ADDR_STATUS, 8'h10);
  endtask

  task automatic t_array;
    array_busy = 1'b1;
    step(2);
    rd(ADDR_STATUS, 8'h11);
    array_busy = 1'b0;
    strobe(0);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_EXT_STAT, 8'h00);
    read_ecc = '{result: 2'h2, count: 2'h3};
    strobe(1);
    rd(ADDR_STATUS, 8'h20);
    rd(ADDR_EXT_STAT, 8'h30);
    read_ecc = '{result: 2'h1, count: 2'h2};
    strobe(1);
    rd(ADDR_STATUS, 8'h10);
    // enable low: a fault pulse must be lost
    ce = 1'b0;
    strobe(2);
    ce = 1'b1;
    rd(ADDR_STATUS, 8'h10);
    strobe(2);
    rd(ADDR_STATUS, 8'h18);
    strobe(3);
    rd(ADDR_STATUS, 8'h10);
    strobe(4);
    rd(ADDR_STATUS, 8'h14);
    strobe(5);
    rd(ADDR_STATUS, 8'h10);
    block_prot = 1'b1;
    rd(ADDR_EXT_STAT, 8'h28);
    block_prot = 1'b0;
  endtask

  task automatic t_soft;
    cmd(OP_WREN);
    strobe(2);
    cmd(OP_SOFT_RESET);
    check(n_soft[7:0], 8'h01);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_EXT_STAT, 8'h00);
    rd(ADDR_PROTECT, 8'hb8);
    rd(ADDR_FEATURE, 8'h91);
    rd(ADDR_DRIVE, 8'h60);
  endtask

  task automatic t_freeze;
    wr(ADDR_FEATURE, 8'h99);
    rd(ADDR_FEATURE, 8'h99);
    wr(ADDR_PROTECT, 8'h00);
    rd(ADDR_PROTECT, 8'hb8);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    ce = 1'b1;
    rst_n = 1'b0;
    wp_n = 1'b1;
    otp_nv = 1'b1;
    page0_ecc = '{result: 2'h1, count: 2'h2};
    read_ecc = '{result: 2'h0, count: 2'h0};
    array_busy = 1'b0;
    block_prot = 1'b0;
    strobes = 6'h00;
    miso_last = 1'b0;
    mismatches = 0;
    n_tests = 0;
    n_soft = 0;
    t_reset(1'b1, 8'h90);
    t_rw();
    t_guard();
    t_wel();
    t_array();
    t_soft();
    t_freeze();
    // second power-on: freeze gone, lock follows storage
    t_reset(1'b0, 8'h10);
    tally_and_finish();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

endmodule

`default_nettype wire
